// File: rtl/spc_pkg.sv
// Package of constants and types for the SDRAM pin control block
package spc_pkg;

  // Command codes on {row_strobe_n, column_strobe_n, mem_write_en_n}
  localparam logic [2:0] CMD_NOP     = 3'h7;
  localparam logic [2:0] CMD_ACTIVE  = 3'h3;
  localparam logic [2:0] CMD_READ    = 3'h5;
  localparam logic [2:0] CMD_WRITE   = 3'h4;
  localparam logic [2:0] CMD_PRECH   = 3'h2;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_LMR     = 3'h0;

  // Request codes from the memory controller
  localparam logic [2:0] REQ_NONE    = 3'h0;
  localparam logic [2:0] REQ_ACTIVE  = 3'h1;
  localparam logic [2:0] REQ_READ    = 3'h2;
  localparam logic [2:0] REQ_WRITE   = 3'h3;
  localparam logic [2:0] REQ_PRECH   = 3'h4;
  localparam logic [2:0] REQ_REFRESH = 3'h5;
  localparam logic [2:0] REQ_LMR     = 3'h6;

  // Reset values
  localparam logic       RST_STROBE  = 1'h1;
  localparam logic       RST_MASK    = 1'h1;
  localparam logic       RST_CKE     = 1'h1;

  // Phase of the interface
  typedef enum logic [2:0] {
    SPC_INIT = 3'h1,
    SPC_RUN  = 3'h2,
    SPC_OFF  = 3'h4
  } spc_phase_t;

  // All state of the block
  typedef struct packed {
    logic [1:0]  lclk_sync;
    logic        lclk_prev;
    spc_phase_t  phase;
    logic        mem_clock_out;
    logic        mem_clock_out_oe;
    logic        row_strobe_n;
    logic        column_strobe_n;
    logic        mem_write_en_n;
    logic        mem_clock_enable;
    logic        addr_bit_ten_out;
    logic        shared_addr_bit_ten;
    logic        byte_mask_out;
    logic        cmd_oe;
  } spc_state_t;

endpackage : spc_pkg

// File: rtl/spc_sdram_pin_control.sv
// SDRAM pin control: command strobes, clock enable, address ten and data mask
// Behaviour
// - Row, column strobes and write enable jointly encode each memory command.
// - Data mask stays high from reset release until initialization completes.
// - After initialization the data mask is driven low until the interface is disabled.
// - Address bit ten goes on dedicated output only during SDRAM transfers.
// - Clock enable output follows its request; the memory clock stops only in reset and when the interface is disabled.
module spc_sdram_pin_control
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Link clock from the clock generator, asynchronous
  input  wire logic       link_clk,
  // Controller side
  input  wire logic [2:0] cmd_req,
  input  wire logic       init_done,
  input  wire logic       clk_enable_req,
  input  wire logic       addr_ten_in,
  input  wire logic       interface_disable_bit,
  // Memory pins
  output logic            mem_clock_out,
  output logic            mem_clock_out_oe,
  output logic            row_strobe_n,
  output logic            column_strobe_n,
  output logic            mem_write_en_n,
  output logic            mem_clock_enable,
  output logic            addr_bit_ten_out,
  output logic            shared_addr_bit_ten,
  output logic            byte_mask_out,
  output logic            cmd_oe
);
  import spc_pkg::*;

  // ****************************************************
  // Command encoding
  // ****************************************************

  // Map a request onto the active-low strobe triple
  function automatic logic [2:0] spc_encode(input logic [2:0] req);
    logic [2:0] c;
    c = CMD_NOP;
    unique case (req)
      REQ_ACTIVE:  c = CMD_ACTIVE;
      REQ_READ:    c = CMD_READ;
      REQ_WRITE:   c = CMD_WRITE;
      REQ_PRECH:   c = CMD_PRECH;
      REQ_REFRESH: c = CMD_REFRESH;
      REQ_LMR:     c = CMD_LMR;
      default:     c = CMD_NOP;
    endcase
    return c;
  endfunction

  // ****************************************************
  // State
  // ****************************************************

  spc_state_t st_r;
  spc_state_t st_nxt;
  logic       xfer;
  logic       clk_rise;
  logic [2:0] cmd;

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.lclk_sync = {st_r.lclk_sync[0], link_clk};
    st_nxt.lclk_prev = st_r.lclk_sync[1];
    clk_rise = st_r.lclk_sync[1] & ~st_r.lclk_prev;
    xfer = (cmd_req == REQ_READ) || (cmd_req == REQ_WRITE);
    cmd = spc_encode(cmd_req);
    // Phase tracking
    unique case (st_r.phase)
      SPC_INIT: begin
        if (interface_disable_bit) st_nxt.phase = SPC_OFF;
        else if (init_done) st_nxt.phase = SPC_RUN;
      end
      SPC_RUN: begin
        if (interface_disable_bit) st_nxt.phase = SPC_OFF;
      end
      SPC_OFF: begin
        if (!interface_disable_bit) st_nxt.phase = SPC_INIT;
      end
      default: st_nxt.phase = SPC_INIT;
    endcase
    // Mask high during init and while off, low while running
    st_nxt.byte_mask_out = (st_nxt.phase != SPC_RUN);
    // Clock output is the inverted synced link clock: it falls as a command launches,
    // so each command stands half a period before the memory samples it; low while off
    st_nxt.mem_clock_out = ~st_r.lclk_sync[1] & ~interface_disable_bit;
    st_nxt.mem_clock_out_oe = ~interface_disable_bit;
    st_nxt.cmd_oe = ~interface_disable_bit;
    st_nxt.mem_clock_enable = clk_enable_req;
    // Commands launch on link clock rising edges, NOP there while disabled; strobes hold between edges
    if (clk_rise && !interface_disable_bit) begin
      {st_nxt.row_strobe_n, st_nxt.column_strobe_n, st_nxt.mem_write_en_n} = cmd;
      if (xfer) st_nxt.addr_bit_ten_out = addr_ten_in;
      st_nxt.shared_addr_bit_ten = xfer ? 1'h0 : addr_ten_in;
    end else if (clk_rise) begin
      {st_nxt.row_strobe_n, st_nxt.column_strobe_n, st_nxt.mem_write_en_n} = CMD_NOP;
    end
  end

  // Register the state
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.phase <= SPC_INIT;
      st_r.row_strobe_n <= RST_STROBE;
      st_r.column_strobe_n <= RST_STROBE;
      st_r.mem_write_en_n <= RST_STROBE;
      st_r.mem_clock_enable <= RST_CKE;
      st_r.addr_bit_ten_out <= 1'h1;
      st_r.byte_mask_out <= RST_MASK;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign mem_clock_out       = st_r.mem_clock_out;
  assign mem_clock_out_oe    = st_r.mem_clock_out_oe;
  assign row_strobe_n        = st_r.row_strobe_n;
  assign column_strobe_n     = st_r.column_strobe_n;
  assign mem_write_en_n      = st_r.mem_write_en_n;
  assign mem_clock_enable    = st_r.mem_clock_enable;
  assign addr_bit_ten_out    = st_r.addr_bit_ten_out;
  assign shared_addr_bit_ten = st_r.shared_addr_bit_ten;
  assign byte_mask_out       = st_r.byte_mask_out;
  assign cmd_oe              = st_r.cmd_oe;

  // ****************************************************
  // Assertions
  // ****************************************************

  // Two edges with reset held low
  sequence in_reset_s;
    !nrst ##1 !nrst;
  endsequence

  // Interface running after initialization
  sequence run_seen_s;
    st_r.phase == SPC_RUN;
  endsequence

  // Enabled command slot carrying a given request
  sequence slot_s(logic [2:0] req);
    clk_rise && !interface_disable_bit && (cmd_req == req);
  endsequence

  // Pins after reset: no-operation, mask high, clock enable high, pins released
  rst_vals_a: assert property (@(posedge ref_clk)
    in_reset_s |-> ({row_strobe_n, column_strobe_n, mem_write_en_n} == CMD_NOP) &&
      byte_mask_out && mem_clock_enable && !cmd_oe && !mem_clock_out_oe)
    else $error("reset pin values wrong");

  // Data mask: high while initializing or off, low once running
  mask_init_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r.phase == SPC_INIT) && !init_done |=> byte_mask_out)
    else $error("mask low before init done");
  mask_drop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r.phase == SPC_INIT) && init_done && !interface_disable_bit |=> !byte_mask_out)
    else $error("mask high after init done");
  mask_run_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    run_seen_s ##1 run_seen_s |-> !byte_mask_out)
    else $error("mask high after init");
  off_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    interface_disable_bit [*2] |-> byte_mask_out)
    else $error("mask low while off");

  // Strobe triple: encoding per slot, no-operation when idle or refused, held between slots
  nop_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(clk_rise) && $past(cmd_req) == REQ_NONE |->
      {row_strobe_n, column_strobe_n, mem_write_en_n} == CMD_NOP)
    else $error("idle not nop");
  cmd_enc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    slot_s(REQ_WRITE) |=> {row_strobe_n, column_strobe_n, mem_write_en_n} == CMD_WRITE)
    else $error("write encoding wrong");
  rd_enc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    slot_s(REQ_READ) |=> {row_strobe_n, column_strobe_n, mem_write_en_n} == CMD_READ)
    else $error("read encoding wrong");
  act_enc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    slot_s(REQ_ACTIVE) |=> {row_strobe_n, column_strobe_n, mem_write_en_n} == CMD_ACTIVE)
    else $error("activate encoding wrong");
  ref_enc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    slot_s(REQ_REFRESH) |=> {row_strobe_n, column_strobe_n, mem_write_en_n} == CMD_REFRESH)
    else $error("refresh encoding wrong");
  off_nop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_rise && interface_disable_bit |=>
      {row_strobe_n, column_strobe_n, mem_write_en_n} == CMD_NOP)
    else $error("command issued while off");
  strobe_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !clk_rise |=> $stable({row_strobe_n, column_strobe_n, mem_write_en_n}))
    else $error("strobes moved between slots");

  // Address ten: dedicated pin only on transfers, shared pin otherwise
  a10_xfer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_rise && !interface_disable_bit && xfer |=>
      addr_bit_ten_out == $past(addr_ten_in) && !shared_addr_bit_ten)
    else $error("a10 not routed");
  a10_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(clk_rise && !interface_disable_bit && xfer) |=> $stable(addr_bit_ten_out))
    else $error("a10 moved outside transfer");
  sa10_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_rise && !interface_disable_bit && !xfer |=> shared_addr_bit_ten == $past(addr_ten_in))
    else $error("shared a10 not routed");

  // Clock enable, memory clock and pin drive
  cke_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 mem_clock_enable == $past(clk_enable_req))
    else $error("cke mismatch");
  clk_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    interface_disable_bit |=> !mem_clock_out && !mem_clock_out_oe)
    else $error("clock not stopped");
  oe_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !interface_disable_bit |=> cmd_oe && mem_clock_out_oe)
    else $error("pins not driven");

endmodule // spc_sdram_pin_control

// File: dv/spc_mem_model.sv
// Behavioural SDRAM partner that captures commands and the data mask
module spc_mem_model
  import spc_pkg::*;
(
  // Memory pins
  input  wire logic       mem_clock_out,
  input  wire logic [2:0] cmd,
  input  wire logic       byte_mask_out,
  // Observation
  output logic            write_taken,
  output logic            dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Capture on the rising memory clock, half a period after the strobes launch
  always_ff @(posedge mem_clock_out) begin
    write_taken <= (cmd == CMD_WRITE) && !byte_mask_out;
    dq_oe       <= (cmd == CMD_READ) && !byte_mask_out;
  end
endmodule // spc_mem_model

// File: dv/tb.sv
// Testbench for the SDRAM pin control block
module tb
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 0, nrst = 0, link_clk = 0, init_done = 0, clk_enable_req = 1;
  logic       addr_ten_in = 0, interface_disable_bit = 0;
  logic [2:0] cmd_req = REQ_NONE;
  wire  [2:0] mcmd;
  logic       mclk, mclk_oe, cke, a10, sa10, mask, oe, wr_ok, rd_oe;
  int         fails = 0, check_count = 0;
  logic [2:0] reqs [7] = '{REQ_ACTIVE, REQ_WRITE, REQ_READ, REQ_PRECH, REQ_REFRESH, REQ_LMR, REQ_NONE};
  logic [2:0] cmds [7] = '{CMD_ACTIVE, CMD_WRITE, CMD_READ, CMD_PRECH, CMD_REFRESH, CMD_LMR, CMD_NOP};
  // Block clock, and a free-running link clock offset from every block clock edge
  always #12.5 ref_clk = ~ref_clk;
  initial begin
    #5;
    forever #100 link_clk = ~link_clk;
  end
  // Device under test and memory partner
  spc_sdram_pin_control u_spc_sdram_pin_control (.ref_clk(ref_clk), .nrst(nrst),
    .link_clk(link_clk), .cmd_req(cmd_req), .init_done(init_done),
    .clk_enable_req(clk_enable_req), .addr_ten_in(addr_ten_in),
    .interface_disable_bit(interface_disable_bit), .mem_clock_out(mclk),
    .mem_clock_out_oe(mclk_oe), .row_strobe_n(mcmd[2]), .column_strobe_n(mcmd[1]),
    .mem_write_en_n(mcmd[0]), .mem_clock_enable(cke), .addr_bit_ten_out(a10),
    .shared_addr_bit_ten(sa10), .byte_mask_out(mask), .cmd_oe(oe));
  spc_mem_model u_spc_mem_model (.mem_clock_out(mclk), .cmd(mcmd), .byte_mask_out(mask),
    .write_taken(wr_ok), .dq_oe(rd_oe));
  // Compare and count
  task automatic chk(logic [2:0] got, logic [2:0] exp, string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Wait at falling block clock edges for the link clock to reach a level, bounded
  task automatic wait_link(logic lvl);
    int n;
    n = 0;
    while (link_clk !== lvl && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (link_clk !== lvl) begin
      fails++;
      $display("BAD %0t link clock stuck", $time);
      final_report();
    end
  endtask
  // Hold one request over a link rise, check the strobes, let the model capture
  task automatic run(logic [2:0] req, logic [2:0] exp);
    wait_link(1'b1);
    wait_link(1'b0);
    cmd_req = req;
    wait_link(1'b1);
    repeat (6) @(negedge ref_clk);
    chk(mcmd, exp, "strobes");
    cmd_req = REQ_NONE;
    repeat (3) @(negedge ref_clk);
  endtask
  // Pin values while reset is held
  task automatic t_reset();
    chk(mcmd, CMD_NOP, "reset cmd");
    chk({2'h0, mask}, {2'h0, RST_MASK}, "reset mask");
    chk({2'h0, cke}, {2'h0, RST_CKE}, "reset cke");
    $display("t_reset done");
  endtask
  // Before initialization the mask stays high and writes are dropped
  task automatic t_init();
    addr_ten_in = 1;
    run(REQ_WRITE, CMD_WRITE);
    chk({2'h0, mask}, 3'h1, "init mask");
    chk({2'h0, wr_ok}, 3'h0, "masked write");
    run(REQ_READ, CMD_READ);
    chk({2'h0, rd_oe}, 3'h0, "masked read");
    $display("t_init done");
  endtask
  // Every request code after initialization, with address ten routing
  task automatic t_run();
    init_done = 1;
    repeat (2) @(negedge ref_clk);
    chk({2'h0, mask}, 3'h0, "run mask");
    chk({1'h0, mclk_oe, oe}, 3'h3, "pins driven");
    for (int i = 0; i < 7; i++) begin
      addr_ten_in = (reqs[i] == REQ_NONE);
      run(reqs[i], cmds[i]);
      if (reqs[i] == REQ_WRITE) chk({wr_ok, a10, sa10}, 3'h4, "write a10");
      if (reqs[i] == REQ_READ) chk({2'h0, rd_oe}, 3'h1, "read oe");
    end
    chk({mask, a10, sa10}, 3'h1, "idle a10");
    $display("t_run done");
  endtask
  // Clock enable follows its request
  task automatic t_cke();
    logic moved;
    logic first;
    clk_enable_req = 0;
    repeat (2) @(negedge ref_clk);
    chk({2'h0, cke}, 3'h0, "cke low");
    clk_enable_req = 1;
    repeat (2) @(negedge ref_clk);
    chk({2'h0, cke}, 3'h1, "cke high");
    first = mclk;
    moved = 0;
    repeat (16) begin
      @(negedge ref_clk);
      if (mclk !== first) moved = 1;
    end
    chk({2'h0, moved}, 3'h1, "clock runs");
    $display("t_cke done");
  endtask
  // Disabled interface refuses commands and stops the memory clock
  task automatic t_off();
    logic moved;
    interface_disable_bit = 1;
    run(REQ_WRITE, CMD_NOP);
    moved = 0;
    repeat (16) begin
      @(negedge ref_clk);
      if (mclk !== 1'b0) moved = 1;
    end
    chk({2'h0, moved}, 3'h0, "clock stopped");
    chk({2'h0, mask}, 3'h1, "off mask");
    chk({1'h0, mclk_oe, oe}, 3'h0, "pins released");
    $display("t_off done");
  endtask
  // Verdict
  task automatic final_report();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    t_reset();
    nrst = 1;
    t_init();
    t_run();
    t_cke();
    t_off();
    final_report();
  end
endmodule // tb
